// ===== design/gsc_pkg.sv
// Summary of operation
// - commands and data words are 16-bit unsigned, most significant byte first.
// - every 16-bit data word is followed directly by an 8-bit checksum.
// - four transaction kinds: read, write, bare command, command then fetch.
// - read header is not acknowledged until the command's execution time has elapsed.
// - begin_cyclic_sampling 0x21b1 leaves idle and refreshes results every 5 seconds.
// - fetch_sample_set 0xec05 takes 1 ms, allowed while sampling, returns three words.
// - result buffer is emptied when fetch_sample_set completes, so each result is fetched once.
// - measurement read with an empty buffer is answered with a not-acknowledge.
// - controller may NACK any data byte then STOP; device releases and drops the rest.
// - halt_cyclic_sampling 0x3f86 returns to idle; other commands ignored for 500 ms.
// - heat bias and site elevation write/fetch commands take 1 ms, idle only.
// - forced trim 0x362f fetches after 400 ms; trim switch 1 ms, commit 800 ms.
// - internal check 10000 ms, shipped restore 1200 ms, reload 20 ms, identifier 1 ms.
// - after power-up the device needs up to 1000 ms before accepting commands.
// - the device answers only to 7-bit target address 0x62.
// - all commands and parameters share one 16-bit command code space.
package gsc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam logic [6:0] TGT_ADDR = 7'h62;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  // times in milliseconds
  localparam logic [13:0] T_BOOT_MS = 14'd1000;
  localparam logic [13:0] T_PERIOD_MS = 14'd5000;
  localparam logic [13:0] T_HALT_MS = 14'd500;
  localparam logic [13:0] T_SHORT_MS = 14'd1;
  localparam logic [13:0] T_TRIM_MS = 14'd400;
  localparam logic [13:0] T_COMMIT_MS = 14'd800;
  localparam logic [13:0] T_CHECK_MS = 14'd10000;
  localparam logic [13:0] T_RESTORE_MS = 14'd1200;
  localparam logic [13:0] T_RELOAD_MS = 14'd20;
  // command codes
  localparam logic [15:0] CMD_BEGIN_CYC = 16'h21B1;
  localparam logic [15:0] CMD_FETCH_SAMPLE = 16'hEC05;
  localparam logic [15:0] CMD_HALT_CYC = 16'h3F86;
  localparam logic [15:0] CMD_QUERY_PENDING = 16'hE4B0;
  localparam logic [15:0] CMD_LOAD_PRESSURE = 16'hE000;
  localparam logic [15:0] CMD_WRITE_BIAS = 16'h241D;
  localparam logic [15:0] CMD_FETCH_BIAS = 16'h2318;
  localparam logic [15:0] CMD_WRITE_ELEV = 16'h2427;
  localparam logic [15:0] CMD_FETCH_ELEV = 16'h2322;
  localparam logic [15:0] CMD_FORCED_TRIM = 16'h362F;
  localparam logic [15:0] CMD_WRITE_ATRIM = 16'h2416;
  localparam logic [15:0] CMD_FETCH_ATRIM = 16'h2313;
  localparam logic [15:0] CMD_COMMIT = 16'h3615;
  localparam logic [15:0] CMD_FETCH_ID = 16'h3682;
  localparam logic [15:0] CMD_SELF_CHECK = 16'h3639;
  localparam logic [15:0] CMD_RESTORE = 16'h3632;
  localparam logic [15:0] CMD_RELOAD = 16'h3646;
  // values after reset and fixed answers
  localparam logic [15:0] BIAS_RST = 16'h05DA;
  localparam logic [15:0] ELEV_RST = 16'h0000;
  localparam logic [15:0] PRESS_RST = 16'h0000;
  localparam logic ATRIM_RST = 1'b1;
  localparam logic [15:0] TRIM_ZERO = 16'h8000;
  localparam logic [15:0] CHECK_PASS = 16'h0000;
  localparam logic [15:0] PENDING_YES = 16'h0001;
  // identifier words: arbitrary values
  localparam logic [15:0] ID_W0 = 16'h1234;
  localparam logic [15:0] ID_W1 = 16'h5678;
  localparam logic [15:0] ID_W2 = 16'h9ABC;

  typedef enum logic [2:0] {K_NONE = 3'h0, K_BARE = 3'h1, K_WRITE = 3'h2, K_READ = 3'h3,
    K_FETCH = 3'h4} gsc_kind_t;
  typedef enum logic [4:0] {L_IDLE = 5'h01, L_RECV = 5'h02, L_ACK = 5'h04, L_SEND = 5'h08,
    L_CHECK = 5'h10} gsc_lstate_t;
  typedef enum logic [2:0] {M_BOOT = 3'h1, M_IDLE = 3'h2, M_CYC = 3'h4} gsc_mode_t;

  // one byte through the checksum, msb first
  function automatic logic [7:0] crc8_byte(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++)
    begin
      r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [7:0] crc8_word(input logic [15:0] w);
    return crc8_byte(crc8_byte(CRC_INIT, w[15:8]), w[7:0]);
  endfunction

  // transaction kind of a code; unknown codes are K_NONE
  function automatic gsc_kind_t cmd_kind(input logic [15:0] c);
    case (c)
      CMD_BEGIN_CYC, CMD_HALT_CYC, CMD_COMMIT, CMD_RESTORE, CMD_RELOAD: return K_BARE;
      CMD_LOAD_PRESSURE, CMD_WRITE_BIAS, CMD_WRITE_ELEV, CMD_WRITE_ATRIM: return K_WRITE;
      CMD_FETCH_SAMPLE, CMD_QUERY_PENDING, CMD_FETCH_BIAS, CMD_FETCH_ELEV, CMD_FETCH_ATRIM,
      CMD_FETCH_ID, CMD_SELF_CHECK: return K_READ;
      CMD_FORCED_TRIM: return K_FETCH;
      default: return K_NONE;
    endcase
  endfunction

  // execution time; zero means no busy phase
  function automatic logic [13:0] cmd_ms(input logic [15:0] c);
    case (c)
      CMD_HALT_CYC: return T_HALT_MS;
      CMD_FORCED_TRIM: return T_TRIM_MS;
      CMD_COMMIT: return T_COMMIT_MS;
      CMD_SELF_CHECK: return T_CHECK_MS;
      CMD_RESTORE: return T_RESTORE_MS;
      CMD_RELOAD: return T_RELOAD_MS;
      CMD_BEGIN_CYC: return 14'd0;
      default: return T_SHORT_MS;
    endcase
  endfunction

  // codes that stay legal while cyclic sampling runs
  function automatic logic cmd_cyc_ok(input logic [15:0] c);
    return c == CMD_FETCH_SAMPLE || c == CMD_QUERY_PENDING || c == CMD_HALT_CYC ||
      c == CMD_LOAD_PRESSURE;
  endfunction
endpackage

// ===== design/gsc_engine.sv
`timescale 1ns/1ps
`default_nettype none
module gsc_engine
#(
  parameter int unsigned CYC_PER_MS = gsc_pkg::CLK_HZ / 1000
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [15:0] gas_ppm,
  input wire logic [15:0] temp_raw,
  input wire logic [15:0] hum_raw,
  output logic busy,
  output logic sampling,
  output logic [15:0] heat_bias,
  output logic [15:0] site_elevation,
  output logic [15:0] air_pressure,
  output logic auto_trim
);
  import gsc_pkg::*;

  localparam logic [19:0] CYC_M1 = 20'(CYC_PER_MS - 1);

  // ----------------------------------------
  // state of both domains
  // ----------------------------------------
  typedef struct packed {
    gsc_lstate_t st;
    logic scl1, scl2, sclp, sda1, sda2, sdap;
    logic busy1, busy2, rv1, rv2, cyc1, cyc2;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [2:0] idx;
    logic rd, wr, pend, rd_done, drive, req_t, done_t;
    logic [15:0] cmd, data;
    logic [1:0] wi, pos;
  } gsc_link_t;

  typedef struct packed {
    gsc_mode_t mode;
    logic r1, r2, r3, d1, d2, d3;
    logic [19:0] presc;
    logic [13:0] left, per;
    logic busy, fresh, rv;
    logic [15:0] pcmd, gas, tmp, hum, w0, w1, w2, bias, elev, press;
    logic [1:0] n;
    logic atrim;
  } gsc_core_t;

  gsc_link_t l_q, l_d;
  gsc_core_t c_q, c_d;
  logic lrst1_q, lrst_q;
  logic rise, fall, start_c, stop_c, ack, load, tick, ev, dn;
  logic [15:0] wsel, ncmd;
  logic [7:0] tx_now;
  gsc_kind_t k;

  // ----------------------------------------
  // link domain
  // ----------------------------------------
  // reset carried over into the link clock by two flops
  always_ff @(posedge link_clk)
  begin
    lrst1_q <= rst;
    lrst_q <= lrst1_q;
  end

  // byte engine of the bus target; scl is oversampled, never used as a clock
  always_comb
  begin
    l_d = l_q;
    ack = 1'b0;
    load = 1'b0;
    k = K_NONE;
    ncmd = {l_q.cmd[15:8], l_q.sh};
    l_d.scl1 = scl_in;
    l_d.scl2 = l_q.scl1;
    l_d.sclp = l_q.scl2;
    l_d.sda1 = sda_in;
    l_d.sda2 = l_q.sda1;
    l_d.sdap = l_q.sda2;
    l_d.busy1 = c_q.busy;
    l_d.busy2 = l_q.busy1;
    l_d.rv1 = c_q.rv;
    l_d.rv2 = l_q.rv1;
    l_d.cyc1 = c_q.mode == M_CYC;
    l_d.cyc2 = l_q.cyc1;
    rise = l_q.scl2 & ~l_q.sclp;
    fall = ~l_q.scl2 & l_q.sclp;
    start_c = l_q.scl2 & l_q.sclp & l_q.sdap & ~l_q.sda2;
    stop_c = l_q.scl2 & l_q.sclp & ~l_q.sdap & l_q.sda2;
    // a word is only handed on once its frame has closed
    if (start_c || stop_c)
    begin
      if (l_q.pend)
      begin
        l_d.req_t = ~l_q.req_t;
      end
      if (l_q.rd_done)
      begin
        l_d.done_t = ~l_q.done_t;
      end
      l_d.pend = 1'b0;
      l_d.rd_done = 1'b0;
      l_d.drive = 1'b0;
      l_d.cnt = 4'h0;
      l_d.idx = 3'h0;
      l_d.st = start_c ? L_RECV : L_IDLE;
    end
    else
    begin
      unique case (l_q.st)
        L_IDLE:
        begin
          l_d.drive = 1'b0;
        end
        L_RECV:
        begin
          if (rise)
          begin
            l_d.sh = {l_q.sh[6:0], l_q.sda2};
            l_d.cnt = l_q.cnt + 4'h1;
          end
          if (fall && l_q.cnt == 4'h8)
          begin
            case (l_q.idx)
              3'h0:
              begin
                l_d.rd = l_q.sh[0];
                ack = l_q.sh[7:1] == TGT_ADDR && (!l_q.sh[0] || (l_q.rv2 && !l_q.busy2));
                l_d.rd_done = ack & l_q.sh[0];
                l_d.wi = 2'h0;
                l_d.pos = 2'h0;
              end
              3'h1:
              begin
                l_d.cmd[15:8] = l_q.sh;
                ack = 1'b1;
              end
              3'h2:
              begin
                k = cmd_kind(ncmd);
                l_d.cmd = ncmd;
                ack = k != K_NONE && !l_q.busy2 && (!l_q.cyc2 || cmd_cyc_ok(ncmd));
                l_d.wr = k == K_WRITE || k == K_FETCH;
                l_d.pend = ack && (k == K_BARE || k == K_READ);
              end
              3'h3:
              begin
                l_d.data[15:8] = l_q.sh;
                ack = l_q.wr;
              end
              3'h4:
              begin
                l_d.data[7:0] = l_q.sh;
                ack = 1'b1;
              end
              3'h5:
              begin
                ack = l_q.sh == crc8_word(l_q.data);
                l_d.pend = ack;
              end
              default: ack = 1'b0;
            endcase
            l_d.idx = l_q.idx + 3'h1;
            l_d.cnt = 4'h0;
            l_d.drive = ack;
            l_d.st = ack ? L_ACK : L_IDLE;
          end
        end
        L_ACK:
        begin
          if (fall)
          begin
            l_d.drive = 1'b0;
            l_d.st = L_RECV;
            load = l_q.rd;
          end
        end
        L_SEND:
        begin
          if (rise)
          begin
            l_d.cnt = l_q.cnt + 4'h1;
          end
          if (fall)
          begin
            if (l_q.cnt == 4'h8)
            begin
              l_d.drive = 1'b0;
              l_d.st = L_CHECK;
            end
            else
            begin
              l_d.sh = {l_q.sh[6:0], 1'b0};
              l_d.drive = ~l_q.sh[6];
            end
          end
        end
        L_CHECK:
        begin
          // a released data line at the acknowledge slot ends the read
          if (rise && l_q.sda2)
          begin
            l_d.st = L_IDLE;
          end
          else if (fall)
          begin
            load = 1'b1;
          end
        end
      endcase
    end
    // next answer byte; words past the count read as all ones
    wsel = l_q.wi == 2'h0 ? c_q.w0 : (l_q.wi == 2'h1 ? c_q.w1 : c_q.w2);
    if (l_q.wi >= c_q.n)
    begin
      tx_now = 8'hFF;
    end
    else
    begin
      tx_now = l_q.pos == 2'h0 ? wsel[15:8] : (l_q.pos == 2'h1 ? wsel[7:0] : crc8_word(wsel));
    end
    if (load)
    begin
      l_d.sh = tx_now;
      l_d.drive = ~tx_now[7];
      l_d.cnt = 4'h0;
      l_d.st = L_SEND;
      l_d.pos = l_q.pos == 2'h2 ? 2'h0 : l_q.pos + 2'h1;
      l_d.wi = l_q.pos == 2'h2 && l_q.wi != 2'h3 ? l_q.wi + 2'h1 : l_q.wi;
    end
  end

  // link registers
  always_ff @(posedge link_clk)
  begin
    if (lrst_q)
    begin
      l_q <= '0;
      l_q.st <= L_IDLE;
      l_q.scl1 <= 1'b1;
      l_q.scl2 <= 1'b1;
      l_q.sclp <= 1'b1;
      l_q.sda1 <= 1'b1;
      l_q.sda2 <= 1'b1;
      l_q.sdap <= 1'b1;
    end
    else
    begin
      l_q <= l_d;
    end
  end

  // ----------------------------------------
  // core domain
  // ----------------------------------------
  // command words stay still in the link while a request toggle is in flight
  always_comb
  begin
    c_d = c_q;
    c_d.r1 = l_q.req_t;
    c_d.r2 = c_q.r1;
    c_d.r3 = c_q.r2;
    c_d.d1 = l_q.done_t;
    c_d.d2 = c_q.d1;
    c_d.d3 = c_q.d2;
    ev = c_q.r2 ^ c_q.r3;
    dn = c_q.d2 ^ c_q.d3;
    tick = c_q.presc == CYC_M1;
    c_d.presc = tick ? 20'h0 : c_q.presc + 20'h1;
    // execution timer in whole milliseconds
    if (tick && c_q.left != 14'h0)
    begin
      c_d.left = c_q.left - 14'h1;
      if (c_q.left == 14'h1)
      begin
        c_d.busy = 1'b0;
        if (c_q.mode == M_BOOT)
        begin
          c_d.mode = M_IDLE;
        end
        else
        begin
          c_d.rv = 1'b1;
          c_d.n = 2'h1;
          case (c_q.pcmd)
            CMD_FETCH_SAMPLE:
            begin
              c_d.rv = c_q.fresh;
              c_d.n = 2'h3;
              c_d.w0 = c_q.gas;
              c_d.w1 = c_q.tmp;
              c_d.w2 = c_q.hum;
              c_d.fresh = 1'b0;
            end
            CMD_QUERY_PENDING: c_d.w0 = c_q.fresh ? PENDING_YES : 16'h0000;
            CMD_FETCH_BIAS: c_d.w0 = c_q.bias;
            CMD_FETCH_ELEV: c_d.w0 = c_q.elev;
            CMD_FETCH_ATRIM: c_d.w0 = {15'h0, c_q.atrim};
            CMD_FORCED_TRIM: c_d.w0 = l_q.data - gas_ppm + TRIM_ZERO;
            CMD_SELF_CHECK: c_d.w0 = CHECK_PASS;
            CMD_FETCH_ID:
            begin
              c_d.n = 2'h3;
              c_d.w0 = ID_W0;
              c_d.w1 = ID_W1;
              c_d.w2 = ID_W2;
            end
            default: c_d.rv = 1'b0;
          endcase
        end
      end
    end
    // a finished read-out retires the answer
    if (dn)
    begin
      c_d.rv = 1'b0;
    end
    // a new command starts its busy phase and its immediate effects
    if (ev)
    begin
      c_d.pcmd = l_q.cmd;
      c_d.left = cmd_ms(l_q.cmd);
      c_d.busy = cmd_ms(l_q.cmd) != 14'h0;
      c_d.rv = 1'b0;
      case (l_q.cmd)
        CMD_BEGIN_CYC:
        begin
          c_d.mode = M_CYC;
          c_d.per = 14'h0;
        end
        CMD_HALT_CYC:
        begin
          c_d.mode = M_IDLE;
          c_d.fresh = 1'b0;
        end
        CMD_LOAD_PRESSURE: c_d.press = l_q.data;
        CMD_WRITE_BIAS: c_d.bias = l_q.data;
        CMD_WRITE_ELEV: c_d.elev = l_q.data;
        CMD_WRITE_ATRIM: c_d.atrim = l_q.data[0];
        CMD_RESTORE:
        begin
          c_d.bias = BIAS_RST;
          c_d.elev = ELEV_RST;
          c_d.press = PRESS_RST;
          c_d.atrim = ATRIM_RST;
        end
        default: c_d.mode = c_q.mode;
      endcase
    end
    // sampling period; placed last so a new sample beats a same-cycle clear
    if (c_q.mode == M_CYC && tick)
    begin
      if (c_q.per == T_PERIOD_MS - 14'h1)
      begin
        c_d.per = 14'h0;
        c_d.fresh = 1'b1;
        c_d.gas = gas_ppm;
        c_d.tmp = temp_raw;
        c_d.hum = hum_raw;
      end
      else
      begin
        c_d.per = c_q.per + 14'h1;
      end
    end
  end

  // core registers; power-up counts as a busy phase
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      c_q <= '0;
      c_q.mode <= M_BOOT;
      c_q.left <= T_BOOT_MS;
      c_q.busy <= 1'b1;
      c_q.bias <= BIAS_RST;
      c_q.elev <= ELEV_RST;
      c_q.press <= PRESS_RST;
      c_q.atrim <= ATRIM_RST;
    end
    else
    begin
      c_q <= c_d;
    end
  end

  // open-drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = l_q.drive;
  assign busy = c_q.busy;
  assign sampling = c_q.mode == M_CYC;
  assign heat_bias = c_q.bias;
  assign site_elevation = c_q.elev;
  assign air_pressure = c_q.press;
  assign auto_trim = c_q.atrim;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  wrong_addr_a: assert property (@(posedge link_clk) disable iff (lrst_q)
    (l_q.st == L_RECV && fall && l_q.cnt == 4'h8 && l_q.idx == 3'h0 && !start_c && !stop_c &&
    l_q.sh[7:1] != TGT_ADDR) |=> !l_q.drive && l_q.st == L_IDLE)
    else $error("foreign address acknowledged");
  read_gate_a: assert property (@(posedge link_clk) disable iff (lrst_q)
    (l_q.st == L_RECV && fall && l_q.cnt == 4'h8 && l_q.idx == 3'h0 && !start_c && !stop_c &&
    l_q.sh[0] && !l_q.rv2) |=> !l_q.drive ##1 !l_q.drive)
    else $error("read header acknowledged before answer ready");
  busy_nack_a: assert property (@(posedge link_clk) disable iff (lrst_q)
    (l_q.st == L_RECV && fall && l_q.cnt == 4'h8 && l_q.idx == 3'h2 && !start_c && !stop_c &&
    l_q.busy2) |=> !l_q.drive && !l_q.pend)
    else $error("command acknowledged while busy");
  crc_nack_a: assert property (@(posedge link_clk) disable iff (lrst_q)
    (l_q.st == L_RECV && fall && l_q.cnt == 4'h8 && l_q.idx == 3'h5 && !start_c && !stop_c &&
    l_q.sh != crc8_word(l_q.data)) |=> !l_q.drive && !l_q.pend)
    else $error("bad checksum acknowledged");
  early_end_a: assert property (@(posedge link_clk) disable iff (lrst_q)
    (l_q.st == L_CHECK && rise && l_q.sda2 && !start_c && !stop_c) |=> (!l_q.drive) [*3])
    else $error("bus not released after controller nack");
  boot_hold_a: assert property (@(posedge clock) disable iff (rst)
    (c_q.mode == M_BOOT && !(tick && c_q.left == 14'h1)) |=> c_q.mode == M_BOOT && c_q.busy)
    else $error("boot left early");
  cyc_start_a: assert property (@(posedge clock) disable iff (rst)
    (ev && l_q.cmd == CMD_BEGIN_CYC) |=> c_q.mode == M_CYC && c_q.per == 14'h0 && !c_q.busy)
    else $error("cyclic sampling did not start");
  new_sample_a: assert property (@(posedge clock) disable iff (rst)
    (c_q.mode == M_CYC && tick && c_q.per == T_PERIOD_MS - 14'h1) |=> c_q.fresh && c_q.gas ==
    $past(gas_ppm))
    else $error("period end without new sample");
  fetch_empty_a: assert property (@(posedge clock) disable iff (rst)
    (tick && c_q.left == 14'h1 && c_q.mode != M_BOOT && c_q.pcmd == CMD_FETCH_SAMPLE && !dn &&
    !(c_q.mode == M_CYC && c_q.per == T_PERIOD_MS - 14'h1)) |=> !c_q.fresh && c_q.rv ==
    $past(c_q.fresh))
    else $error("result buffer not emptied by fetch");
  halt_hold_a: assert property (@(posedge clock) disable iff (rst)
    (ev && l_q.cmd == CMD_HALT_CYC) |=> c_q.mode == M_IDLE && c_q.busy && c_q.left == T_HALT_MS)
    else $error("halt did not hold off commands");
endmodule
`default_nettype wire

// ===== bench/gsc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// bus controller on the far side of the link
// ------
module gsc_ctrl_model (
  input wire logic link_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // both lines released at power-up, the pull-ups hold them high
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  // data moves only in the low phase, two link clocks after the clock falls, one link clock before the device lets go of its last bit
  task automatic bit_x(input logic b, output logic r);
    tick(2);
    sda_pull <= ~b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    r = sda_line; // taken at the end of the high phase, long after the device settles
    scl <= 1'b0;
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start();
    tick(2);
    sda_pull <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_pull <= 1'b1;
    tick(3);
    scl <= 1'b0;
  endtask
  // stop: data rises while the clock is high, then the bus idles
  task automatic stop();
    tick(2);
    sda_pull <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_pull <= 1'b0;
    tick(6);
  endtask
  // one byte msb first, then the acknowledge bit; a released bit reads the far side
  task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx, output logic nk);
    for (int i = 7; i >= 0; i--)
      bit_x(tx[i], rx[i]);
    bit_x(ak, nk);
  endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gsc_pkg::*;
  localparam int unsigned CPM = 5;
  localparam int unsigned LIMIT = 100000;
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic sda_pull;
  logic sda_out;
  logic sda_oe;
  wire sda_line;
  logic [15:0] gas_ppm = 16'h0000;
  logic [15:0] temp_raw = 16'h0000;
  logic [15:0] hum_raw = 16'h0000;
  logic busy;
  logic sampling;
  logic [15:0] heat_bias;
  logic [15:0] site_elevation;
  logic [15:0] air_pressure;
  logic auto_trim;
  logic [31:0] lfsr = 32'hA609A875;
  int unsigned cyc = 0;
  int errors = 0;
  int check_count = 0;
  // ------
  // clocks, wire and instances
  // ------
  always #5 clock = ~clock;
  always #40 link_clk = ~link_clk;
  // open drain: whoever pulls low wins over the pull-up
  assign sda_line = ~sda_oe & ~sda_pull;
  gsc_engine #(.CYC_PER_MS(CPM)) uut (
    .clock(clock),
    .rst(rst),
    .link_clk(link_clk),
    .scl_in(scl),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .gas_ppm(gas_ppm),
    .temp_raw(temp_raw),
    .hum_raw(hum_raw),
    .busy(busy),
    .sampling(sampling),
    .heat_bias(heat_bias),
    .site_elevation(site_elevation),
    .air_pressure(air_pressure),
    .auto_trim(auto_trim)
  );
  gsc_ctrl_model m (
    .link_clk(link_clk),
    .sda_line(sda_line),
    .scl(scl),
    .sda_pull(sda_pull)
  );
  // ------
  // helpers
  // ------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // checksum worked out bit by bit, independent of the design's own helper
  function automatic logic [7:0] crc_of(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--)
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
    return c;
  endfunction
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_ack(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic conclude();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // write transfer; the checksum is sent only when dat is set, flip spoils it on purpose
  task automatic wr(input logic [15:0] code, input logic dat, input logic [15:0] w,
    input logic [7:0] flip, output logic [5:0] nk);
    logic [7:0] rx;
    nk = 6'h00;
    m.start();
    m.xfer({TGT_ADDR, 1'b0}, 1'b1, rx, nk[5]);
    m.xfer(code[15:8], 1'b1, rx, nk[4]);
    m.xfer(code[7:0], 1'b1, rx, nk[3]);
    if (dat)
    begin
      m.xfer(w[15:8], 1'b1, rx, nk[2]);
      m.xfer(w[7:0], 1'b1, rx, nk[1]);
      m.xfer(crc_of(w) ^ flip, 1'b1, rx, nk[0]);
    end
    m.stop();
  endtask
  // read transfer of nb bytes, the last one refused to end it
  task automatic rd(input int nb, output logic [71:0] d, output logic nk);
    logic [7:0] rx;
    logic x;
    d = 72'h0;
    m.start();
    m.xfer({TGT_ADDR, 1'b1}, 1'b1, rx, nk);
    for (int i = 0; i < nb && !nk; i++)
    begin
      m.xfer(8'hFF, i == nb - 1, rx, x);
      d[71 - 8 * i -: 8] = rx;
    end
    m.stop();
  endtask
  task automatic chk_set(input logic [71:0] d, input int nw, input logic [47:0] e);
    for (int i = 0; i < nw; i++)
    begin
      chk_word(d[71 - 24 * i -: 16], e[47 - 16 * i -: 16]);
      chk_word({8'h00, d[55 - 24 * i -: 8]}, {8'h00, crc_of(e[47 - 16 * i -: 16])});
    end
  endtask
  // bounded wait for the end of an execution phase
  task automatic wait_idle(output int n);
    n = 0;
    while (busy !== 1'b0 && n < 12000)
    begin
      @(negedge clock);
      n++;
    end
    if (n >= 12000)
      errors++;
  endtask
  // ------
  // scenarios
  // ------
  initial
  begin
    logic [5:0] nk;
    logic [71:0] d;
    logic a;
    logic [15:0] wv;
    logic [15:0] pv;
    logic [15:0] tv;
    int n;
    int unsigned t0;
    repeat (5) @(posedge link_clk);
    @(posedge clock);
    rst <= 1'b0;
    lfsr = nxt(lfsr);
    gas_ppm <= lfsr[15:0];
    temp_raw <= lfsr[31:16];
    lfsr = nxt(lfsr);
    hum_raw <= lfsr[15:0];
    wv = lfsr[31:16];
    lfsr = nxt(lfsr);
    pv = lfsr[15:0];
    tv = 16'hFFFF; // largest reference, so the trim answer wraps
    @(posedge clock);
    #1;
    chk_ack(busy, 1'b1);
    wait_idle(n);
    chk_ack(n >= 990 * CPM, 1'b1);
    m.start();
    m.xfer({7'h63, 1'b0}, 1'b1, d[7:0], a);
    m.stop();
    chk_ack(a, 1'b1);
    wr(CMD_WRITE_BIAS, 1'b1, wv, 8'h00, nk);
    chk_word({10'h000, nk}, 16'h0000);
    wait_idle(n);
    chk_word(heat_bias, wv);
    wr(CMD_WRITE_ELEV, 1'b1, wv, 8'h01, nk);
    chk_ack(nk[0], 1'b1);
    wait_idle(n);
    chk_word(site_elevation, ELEV_RST);
    wr(CMD_WRITE_ATRIM, 1'b1, 16'h0000, 8'h00, nk);
    wait_idle(n);
    chk_ack(auto_trim, 1'b0);
    wr(CMD_FETCH_ID, 1'b0, 16'h0000, 8'h00, nk);
    wait_idle(n);
    rd(9, d, a);
    chk_ack(a, 1'b0);
    chk_set(d, 3, {ID_W0, ID_W1, ID_W2});
    wr(CMD_FORCED_TRIM, 1'b1, tv, 8'h00, nk);
    rd(3, d, a);
    chk_ack(a, 1'b1);
    wait_idle(n);
    rd(3, d, a);
    chk_ack(a, 1'b0);
    chk_set(d, 1, {tv - gas_ppm + 16'h8000, 32'h0});
    wr(CMD_BEGIN_CYC, 1'b0, 16'h0000, 8'h00, nk);
    t0 = cyc;
    wait_idle(n);
    chk_ack(sampling, 1'b1);
    wr(CMD_FETCH_SAMPLE, 1'b0, 16'h0000, 8'h00, nk);
    wait_idle(n);
    rd(9, d, a);
    chk_ack(a, 1'b1);
    wr(CMD_WRITE_BIAS, 1'b1, ~wv, 8'h00, nk);
    chk_ack(|nk[4:3], 1'b1);
    wr(CMD_LOAD_PRESSURE, 1'b1, pv, 8'h00, nk);
    wait_idle(n);
    chk_word(air_pressure, pv);
    chk_word(heat_bias, wv);
    while (cyc < t0 + 5000 * CPM + 200)
      @(posedge clock);
    wr(CMD_FETCH_SAMPLE, 1'b0, 16'h0000, 8'h00, nk);
    wait_idle(n);
    rd(9, d, a);
    chk_ack(a, 1'b0);
    chk_set(d, 3, {gas_ppm, temp_raw, hum_raw});
    wr(CMD_FETCH_SAMPLE, 1'b0, 16'h0000, 8'h00, nk);
    wait_idle(n);
    rd(9, d, a);
    chk_ack(a, 1'b1);
    wr(CMD_HALT_CYC, 1'b0, 16'h0000, 8'h00, nk);
    t0 = cyc;
    wr(CMD_FETCH_BIAS, 1'b0, 16'h0000, 8'h00, nk);
    chk_ack(|nk[4:3], 1'b1);
    chk_ack(sampling, 1'b0);
    wait_idle(n);
    chk_ack(cyc - t0 >= 490 * CPM && cyc - t0 <= 501 * CPM, 1'b1);
    wr(CMD_FETCH_BIAS, 1'b0, 16'h0000, 8'h00, nk);
    wait_idle(n);
    rd(1, d, a);
    chk_word({8'h00, d[71:64]}, {8'h00, wv[15:8]});
    chk_ack(sda_line, 1'b1);
    chk_ack(sda_out, 1'b0);
    wr(CMD_RESTORE, 1'b0, 16'h0000, 8'h00, nk);
    wait_idle(n);
    chk_word(heat_bias, BIAS_RST);
    chk_ack(auto_trim, ATRIM_RST);
    conclude();
  end
  // cycle count; a run past the ceiling counts as a mismatch
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      errors++;
      conclude();
    end
  end
endmodule
`default_nettype wire
